// ===== hw/rbc_pkg.sv
// Overview of operation
// [R1] serial number read as three config words
// [R2] control bits 0,1 show fifo empty, half
// [R3] control bits 8,9 enable empty/half interrupts
// [R4] control bit 10 starts spy transfers
// [R5] writing control bit 17 soft-resets everything
// [R6] free block address fifo, 64 entries deep
// [R7] block size held in bits 15..2
// [R8] size fifo base held in bits 31..12
// [R9] write pointer update address register
// [R10] valid mask contiguous from bit zero
// [R11] data-in write starts masked scan shift
// [R12] scan bits shifted bit zero first
// [R13] mode-select word masked, loaded before start
// [R14] data-out returns bits captured last shift
// [R15] data-out read while shifting gets retry
// [R16] shared memory window read/write words
// [R17] memory split spy, histogram, descriptors
// [R18] size histogram 256 bins from window start
// [R19] overflow counter after last size bin
// [R20] source module number word after overflow
// [R21] 64-bit word accumulator, low then high
// [R22] bunch crossing histogram 4096 bins
// [R23] each event bumps one size or overflow bin, one crossing bin
package rbc_pkg;
  localparam logic [21:0] OFF_CTRL    = 22'h000000;
  localparam logic [21:0] OFF_BLKADDR = 22'h000004;
  localparam logic [21:0] OFF_SER_LO  = 22'h00005C;
  localparam logic [21:0] OFF_SER_MID = 22'h000060;
  localparam logic [21:0] OFF_SER_HI  = 22'h000064;
  localparam logic [21:0] OFF_BSIZE   = 22'h000080;
  localparam logic [21:0] OFF_SZBASE  = 22'h000084;
  localparam logic [21:0] OFF_PTRUPD  = 22'h000088;
  localparam logic [21:0] OFF_MASK    = 22'h008090;
  localparam logic [21:0] OFF_TDI     = 22'h008094;
  localparam logic [21:0] OFF_TMS     = 22'h008098;
  localparam logic [21:0] OFF_TDO     = 22'h00809C;
  localparam logic [21:0] MEM_LO      = 22'h200000;
  localparam logic [21:0] MEM_HI      = 22'h3FFFFF;
  localparam logic [18:0] W_SIZE_HIST = 19'h00000;
  localparam logic [18:0] W_OVERFLOW  = 19'h00100;
  localparam logic [18:0] W_SOURCE    = 19'h00101;
  localparam logic [18:0] W_ACC_LO    = 19'h00102;
  localparam logic [18:0] W_ACC_HI    = 19'h00103;
  localparam logic [18:0] W_BX_HIST   = 19'h01000;
  localparam int SIZE_BINS  = 256;
  localparam int FIFO_DEPTH = 64;
  localparam int B_EMPTY = 0;
  localparam int B_HALF  = 1;
  localparam int B_IEN_E = 8;
  localparam int B_IEN_H = 9;
  localparam int B_SPY   = 10;
  localparam int B_SRST  = 17;
  localparam logic [31:0] REG_RST   = 32'h00000000;
  localparam logic [31:0] BSIZE_MSK = 32'h0000FFFC;
  localparam logic [31:0] SZB_MSK   = 32'hFFFFF000;
  localparam int CLK_NS      = 20;
  localparam int TCK_HALF_NS = 100;
  localparam int TCK_HALF_CYC = (TCK_HALF_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic        cfg;
    logic        wr;
    logic [21:0] addr;
    logic [31:0] data;
  } rbc_req_t;

  typedef struct packed {
    logic [23:0] words;
    logic [11:0] bx;
    logic [11:0] src;
  } rbc_evt_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] size;
    logic [31:0] szBase;
    logic [31:0] ptrAddr;
  } rbc_dma_t;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_HOST = 2'b01,
    M_EVT  = 2'b10
  } rbc_mst_t;
endpackage

// ===== hw/rbc_bridge.sv
`timescale 1ns/10ps
module rbc_bridge import rbc_pkg::*; (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        busReq,
  input  wire rbc_req_t    busCmd,
  output logic             busAck,
  output logic             busRetry,
  output logic [31:0]      busRdata,
  output logic             intReq,
  input  wire logic [75:0] serialPins,
  input  wire logic        spyValid,
  output logic             dmaGo,
  output rbc_dma_t         dmaCmd,
  input  wire logic        dmaDone,
  output logic             scanTck,
  output logic             scanTms,
  output logic             scanTdi,
  input  wire logic        scanTdoPin,
  input  wire logic        evtValid,
  input  wire rbc_evt_t    evtIn,
  output logic             evtReady,
  output logic             memReq,
  output logic             memWe,
  output logic [18:0]      memAddr,
  output logic [31:0]      memWdata,
  input  wire logic        memAck,
  input  wire logic [31:0] memRdata
);
  logic        srst_reg;
  logic        rst;
  logic [75:0] serS1_reg, serS2_reg;
  logic        tdoS1_reg, tdoS2_reg;
  logic        ienE_reg, ienH_reg, spyEn_reg;
  logic [31:0] bsize_reg, szBase_reg, ptrUpd_reg;
  logic [31:0] mask_reg, tdiW_reg, tmsW_reg, tdoW_reg;
  logic [31:0] fifo_reg [FIFO_DEPTH];
  logic [5:0]  wrPtr_reg, rdPtr_reg;
  logic [6:0]  count_reg;
  logic        fEmpty, fHalf, push, pop;
  logic        dmaBusy_reg;
  logic        hostPend_reg, hostDone, hostWr_reg;
  logic [18:0] hostAddr_reg;
  logic [31:0] hostData_reg;
  logic        take, isMem, tdoBusy, startScan;
  logic        scanBusy_reg;
  logic [5:0]  nBits_reg, idx_reg;
  logic [7:0]  div_reg;
  logic        tick;
  rbc_mst_t    mst_reg;
  rbc_evt_t    ev_reg;
  logic        evPend_reg;
  logic [2:0]  step_reg;
  logic [63:0] acc_reg;

  // soft reset lands one cycle after the write is answered
  assign rst = reset | srst_reg;

  always_ff @(posedge clk) begin
    serS1_reg <= serialPins; // [R1]
    serS2_reg <= serS1_reg;
    tdoS1_reg <= scanTdoPin;
    tdoS2_reg <= tdoS1_reg;
  end

  // bus decode
  assign isMem = (busCmd.addr >= MEM_LO) && (busCmd.addr <= MEM_HI) && !busCmd.cfg; // [R16]
  assign tdoBusy = scanBusy_reg && !busCmd.cfg &&
                   (busCmd.addr == OFF_TDO || busCmd.addr == OFF_TDI); // [R15]
  assign take = busReq && !busAck && !busRetry && !hostPend_reg;
  assign startScan = take && !tdoBusy && !busCmd.cfg && busCmd.wr && busCmd.addr == OFF_TDI;
  assign push = take && !busCmd.cfg && busCmd.wr && busCmd.addr == OFF_BLKADDR &&
                count_reg != 7'(FIFO_DEPTH); // [R6]
  assign pop = spyEn_reg && spyValid && !fEmpty && !dmaBusy_reg; // [R4]
  assign fEmpty = count_reg == 7'h00; // [R2]
  assign fHalf = count_reg <= 7'(FIFO_DEPTH / 2);

  always_ff @(posedge clk) begin
    if (reset) begin
      srst_reg <= 1'b0;
    end else begin
      srst_reg <= take && !busCmd.cfg && busCmd.wr && busCmd.addr == OFF_CTRL &&
                  busCmd.data[B_SRST]; // [R5]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ienE_reg   <= 1'b0;
      ienH_reg   <= 1'b0;
      spyEn_reg  <= 1'b0;
      bsize_reg  <= REG_RST;
      szBase_reg <= REG_RST;
      ptrUpd_reg <= REG_RST;
      mask_reg   <= REG_RST;
      tmsW_reg   <= REG_RST;
      tdiW_reg   <= REG_RST;
    end else if (take && busCmd.wr && !busCmd.cfg) begin
      case (busCmd.addr)
        OFF_CTRL: begin
          ienE_reg  <= busCmd.data[B_IEN_E]; // [R3]
          ienH_reg  <= busCmd.data[B_IEN_H]; // [R3]
          spyEn_reg <= busCmd.data[B_SPY]; // [R4]
        end
        OFF_BSIZE:  bsize_reg  <= busCmd.data & BSIZE_MSK; // [R7]
        OFF_SZBASE: szBase_reg <= busCmd.data & SZB_MSK; // [R8]
        OFF_PTRUPD: ptrUpd_reg <= busCmd.data; // [R9]
        OFF_MASK:   mask_reg   <= busCmd.data; // [R10]
        OFF_TMS:    tmsW_reg   <= busCmd.data; // [R13]
        OFF_TDI: begin
          if (!tdoBusy) begin
            tdiW_reg <= busCmd.data; // [R11]
          end
        end
        default: ;
      endcase
    end
  end

  // answer path; memory reads wait for the shared port
  always_ff @(posedge clk) begin
    if (rst) begin
      busAck       <= 1'b0;
      busRetry     <= 1'b0;
      busRdata     <= REG_RST;
      hostPend_reg <= 1'b0;
      hostWr_reg   <= 1'b0;
      hostAddr_reg <= 19'h00000;
      hostData_reg <= REG_RST;
    end else begin
      busAck   <= 1'b0;
      busRetry <= 1'b0;
      if (hostDone) begin
        hostPend_reg <= 1'b0;
        busAck       <= 1'b1;
        busRdata     <= hostWr_reg ? REG_RST : memRdata;
      end else if (take && tdoBusy) begin
        busRetry <= 1'b1; // [R15]
      end else if (take && isMem) begin
        hostPend_reg <= 1'b1; // [R16]
        hostWr_reg   <= busCmd.wr;
        hostAddr_reg <= 19'((busCmd.addr - MEM_LO) >> 2);
        hostData_reg <= busCmd.data;
      end else if (take) begin
        busAck   <= 1'b1;
        busRdata <= REG_RST;
        if (!busCmd.wr && busCmd.cfg) begin
          case (busCmd.addr)
            OFF_SER_LO:  busRdata <= serS2_reg[31:0]; // [R1]
            OFF_SER_MID: busRdata <= serS2_reg[63:32]; // [R1]
            OFF_SER_HI:  busRdata <= {20'h00000, serS2_reg[75:64]}; // [R1]
            default:     busRdata <= REG_RST;
          endcase
        end else if (!busCmd.wr) begin
          case (busCmd.addr)
            OFF_CTRL: busRdata <= {21'h000000, spyEn_reg, ienH_reg, ienE_reg,
                                   6'h00, fHalf, fEmpty}; // [R2]
            OFF_BSIZE:  busRdata <= bsize_reg;
            OFF_SZBASE: busRdata <= szBase_reg;
            OFF_PTRUPD: busRdata <= ptrUpd_reg;
            OFF_MASK:   busRdata <= mask_reg;
            OFF_TDI:    busRdata <= tdiW_reg;
            OFF_TMS:    busRdata <= tmsW_reg;
            OFF_TDO:    busRdata <= tdoW_reg; // [R14]
            default:    busRdata <= REG_RST;
          endcase
        end
      end
    end
  end

  // free block address fifo; a push when full is dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_reg <= 6'h00;
      rdPtr_reg <= 6'h00;
      count_reg <= 7'h00;
    end else begin
      if (push) begin
        fifo_reg[wrPtr_reg] <= busCmd.data; // [R6]
        wrPtr_reg           <= wrPtr_reg + 6'h01;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 6'h01;
      end
      count_reg <= count_reg + 7'(push) - 7'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      intReq <= 1'b0;
    end else begin
      intReq <= (ienE_reg && fEmpty) || (ienH_reg && fHalf); // [R3]
    end
  end

  // one block per spy transfer; master back end reports done
  always_ff @(posedge clk) begin
    if (rst) begin
      dmaGo       <= 1'b0;
      dmaBusy_reg <= 1'b0;
      dmaCmd      <= '0;
    end else begin
      dmaGo <= pop; // [R4]
      if (pop) begin
        dmaBusy_reg    <= 1'b1;
        dmaCmd.addr    <= fifo_reg[rdPtr_reg];
        dmaCmd.size    <= bsize_reg; // [R7]
        dmaCmd.szBase  <= szBase_reg; // [R8]
        dmaCmd.ptrAddr <= ptrUpd_reg; // [R9]
      end else if (dmaDone) begin
        dmaBusy_reg <= 1'b0;
      end
    end
  end

  // scan shifter, tck from a divider enable
  assign tick = scanBusy_reg && div_reg == 8'(TCK_HALF_CYC - 1);

  always_ff @(posedge clk) begin
    if (rst || !scanBusy_reg || tick) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  function automatic logic [5:0] runLen(input logic [31:0] m);
    logic [5:0] n;
    logic       stop;
    n = 6'h00;
    stop = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (!m[i]) begin
        stop = 1'b1;
      end
      if (!stop) begin
        n = n + 6'h01;
      end
    end
    return n; // [R10]
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      scanBusy_reg <= 1'b0;
      nBits_reg    <= 6'h00;
      idx_reg      <= 6'h00;
      scanTck      <= 1'b0;
      scanTms      <= 1'b0;
      scanTdi      <= 1'b0;
      tdoW_reg     <= REG_RST;
    end else if (startScan) begin
      scanBusy_reg <= runLen(mask_reg) != 6'h00; // [R11]
      nBits_reg    <= runLen(mask_reg);
      idx_reg      <= 6'h00;
      tdoW_reg     <= REG_RST;
      scanTck      <= 1'b0;
      scanTdi      <= busCmd.data[0]; // [R12]
      scanTms      <= tmsW_reg[0]; // [R13]
    end else if (tick) begin
      if (!scanTck) begin
        scanTck           <= 1'b1;
        tdoW_reg[idx_reg[4:0]] <= tdoS2_reg; // [R14]
      end else begin
        scanTck <= 1'b0;
        idx_reg <= idx_reg + 6'h01;
        if (idx_reg + 6'h01 == nBits_reg) begin
          scanBusy_reg <= 1'b0;
        end else begin
          scanTdi <= tdiW_reg[5'(idx_reg + 6'h01)]; // [R12]
          scanTms <= tmsW_reg[5'(idx_reg + 6'h01)]; // [R12]
        end
      end
    end
  end

  // histogram engine; spy buffer area is never addressed here
  function automatic logic [18:0] stepAddr(input logic [2:0] s, input rbc_evt_t e);
    case (s)
      3'h0, 3'h1: stepAddr = (e.words > 24'(SIZE_BINS - 1)) ? W_OVERFLOW // [R19]
                            : W_SIZE_HIST + 19'(e.words[7:0]); // [R18]
      3'h2, 3'h3: stepAddr = W_BX_HIST + 19'(e.bx); // [R22]
      3'h4:       stepAddr = W_SOURCE; // [R20]
      3'h5:       stepAddr = W_ACC_LO; // [R21]
      default:    stepAddr = W_ACC_HI; // [R21]
    endcase // [R17]
  endfunction

  assign hostDone = mst_reg == M_HOST && memAck;

  always_ff @(posedge clk) begin
    if (rst) begin
      evtReady   <= 1'b0;
      evPend_reg <= 1'b0;
      ev_reg     <= '0;
      acc_reg    <= 64'h0000000000000000;
    end else begin
      evtReady <= !evPend_reg && !(evtValid && evtReady);
      if (evtValid && evtReady) begin
        evPend_reg <= 1'b1;
        ev_reg     <= evtIn;
        acc_reg    <= acc_reg + 64'(evtIn.words); // [R21]
      end else if (mst_reg == M_EVT && memAck && step_reg == 3'h6) begin
        evPend_reg <= 1'b0;
      end
    end
  end

  // host has priority over histogram updates between events
  always_ff @(posedge clk) begin
    if (rst) begin
      mst_reg    <= M_IDLE;
      step_reg   <= 3'h0;
      memReq     <= 1'b0;
      memWe      <= 1'b0;
      memAddr    <= 19'h00000;
      memWdata   <= REG_RST;
    end else begin
      case (mst_reg)
        M_IDLE: begin
          if (hostPend_reg && !busAck) begin
            mst_reg  <= M_HOST;
            memReq   <= 1'b1;
            memWe    <= hostWr_reg; // [R16]
            memAddr  <= hostAddr_reg;
            memWdata <= hostData_reg;
          end else if (evPend_reg) begin
            mst_reg  <= M_EVT;
            step_reg <= 3'h0;
            memReq   <= 1'b1;
            memWe    <= 1'b0;
            memAddr  <= stepAddr(3'h0, ev_reg);
          end
        end
        M_HOST: begin
          if (memAck) begin
            memReq     <= 1'b0;
            mst_reg    <= M_IDLE;
          end
        end
        M_EVT: begin
          if (memAck) begin
            step_reg <= step_reg + 3'h1;
            memAddr  <= stepAddr(step_reg + 3'h1, ev_reg);
            memWe    <= 1'b1;
            case (step_reg)
              3'h0, 3'h2: memWdata <= memRdata + 32'h00000001; // [R23]
              3'h1:       memWe    <= 1'b0;
              3'h3:       memWdata <= {20'h00000, ev_reg.src}; // [R20]
              3'h4:       memWdata <= acc_reg[31:0]; // [R21]
              3'h5:       memWdata <= acc_reg[63:32]; // [R21]
              default: begin
                memReq  <= 1'b0;
                memWe   <= 1'b0;
                mst_reg <= M_IDLE;
              end
            endcase
          end
        end
        default: mst_reg <= M_IDLE;
      endcase
    end
  end
endmodule // rbc_bridge

// ===== testbench/rbc_bridge_asserts.sv
`timescale 1ns/10ps
module rbc_bridge_asserts import rbc_pkg::*; (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        busReq,
  input wire rbc_req_t    busCmd,
  input wire logic        busAck,
  input wire logic        busRetry,
  input wire logic [31:0] busRdata,
  input wire logic        intReq,
  input wire logic [75:0] serialPins,
  input wire logic        spyValid,
  input wire logic        dmaGo,
  input wire rbc_dma_t    dmaCmd,
  input wire logic        dmaDone,
  input wire logic        scanTck,
  input wire logic        scanTms,
  input wire logic        scanTdi,
  input wire logic        scanTdoPin,
  input wire logic        evtValid,
  input wire rbc_evt_t    evtIn,
  input wire logic        evtReady,
  input wire logic        memReq,
  input wire logic        memWe,
  input wire logic [18:0] memAddr,
  input wire logic [31:0] memWdata,
  input wire logic        memAck,
  input wire logic [31:0] memRdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_ACK_EXCL: assert property (!(busAck && busRetry))
    else $error("ack and retry together");
  AST_REG_ACK: assert property ($rose(busReq) && !memReq && busCmd.addr < MEM_LO
    && busCmd.addr != OFF_TDO && busCmd.addr != OFF_TDI |=> busAck)
    else $error("register access not acked next cycle");
  AST_MEM_ACK: assert property ($rose(busReq) && !memReq && busCmd.addr >= MEM_LO
    |=> !busAck[*2] ##[1:300] busAck)
    else $error("window access answer timing wrong");
  AST_MEM_HOLD: assert property (memReq && !memAck |=> memReq && $stable(memAddr)
    && $stable(memWe) && $stable(memWdata))
    else $error("memory request changed before ack");
  AST_RETRY_CAUSE: assert property (busRetry |->
    $past(busCmd.addr) == OFF_TDO || $past(busCmd.addr) == OFF_TDI)
    else $error("retry on a non scan register");
  AST_TCK_HALF: assert property ($rose(scanTck) |-> scanTck[*5] ##1 !scanTck)
    else $error("scan clock high time wrong");
  AST_SCAN_STABLE: assert property (scanTck && $past(scanTck)
    |-> $stable(scanTdi) && $stable(scanTms))
    else $error("scan data moved while clock high");
  AST_DMA_PULSE: assert property (dmaGo |=> !dmaGo)
    else $error("block transfer start longer than a pulse");
  AST_RESET_QUIET: assert property ($fell(reset) |-> !busAck && !busRetry && !memReq
    && !dmaGo && !intReq && !scanTck)
    else $error("outputs active right after reset");
  AST_EVT_MEM: assert property (evtValid && evtReady |-> ##[1:300] memReq)
    else $error("event accepted without memory update");
  cover property (busRetry);
  cover property (dmaGo);
  cover property (evtValid && evtReady);
endmodule // rbc_bridge_asserts

bind rbc_bridge rbc_bridge_asserts u_chk (.clk, .reset, .busReq, .busCmd, .busAck,
  .busRetry, .busRdata, .intReq, .serialPins, .spyValid, .dmaGo, .dmaCmd, .dmaDone,
  .scanTck, .scanTms, .scanTdi, .scanTdoPin, .evtValid, .evtIn, .evtReady, .memReq,
  .memWe, .memAddr, .memWdata, .memAck, .memRdata);

// ===== testbench/rbc_far_model.sv
`timescale 1ns/10ps
module rbc_far_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [3:0]  memLat,
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic [18:0] memAddr,
  input  wire logic [31:0] memWdata,
  output logic             memAck,
  output logic [31:0]      memRdata,
  input  wire logic        scanTck,
  input  wire logic        scanTdi,
  output logic             scanTdoPin,
  input  wire logic        dmaGo,
  output logic             dmaDone
);
  logic [31:0] memWords_reg [0:8191];
  logic [3:0]  waitCnt_reg;
  logic [1:0]  dmaCnt_reg;
  logic        chainBit_reg = 1'h1;
  initial begin
    memAck = 1'h0;
    memRdata = 32'h0;
    dmaDone = 1'h0;
    for (int i = 0; i < 8192; i++) memWords_reg[i] = 32'h0;
  end
  // data toggles when not acked, so a stale read never looks right
  always @(posedge clk) begin
    memAck <= 1'h0;
    memRdata <= ~memRdata;
    if (reset) begin
      waitCnt_reg <= 4'h0;
    end else if (memReq && !memAck) begin
      waitCnt_reg <= waitCnt_reg + 4'h1;
      if (waitCnt_reg == memLat) begin
        waitCnt_reg <= 4'h0;
        memAck <= 1'h1;
        memRdata <= memWords_reg[memAddr[12:0]];
        if (memWe) memWords_reg[memAddr[12:0]] <= memWdata;
      end
    end
  end
  // one-stage chain: returns the previous bit
  always @(posedge scanTck) chainBit_reg <= scanTdi;
  assign scanTdoPin = chainBit_reg;
  always @(posedge clk) begin
    dmaDone <= 1'h0;
    if (reset) begin
      dmaCnt_reg <= 2'h0;
    end else if (dmaGo) begin
      dmaCnt_reg <= 2'h3;
    end else if (dmaCnt_reg != 2'h0) begin
      dmaCnt_reg <= dmaCnt_reg - 2'h1;
      dmaDone <= (dmaCnt_reg == 2'h1);
    end
  end
endmodule // rbc_far_model

// ===== testbench/tb_readout_bridge_control_map.sv
`timescale 1ns/10ps
module tb_readout_bridge_control_map import rbc_pkg::*;;
  logic        clk, reset, busReq, busAck, busRetry, intReq, spyValid, dmaGo, dmaDone;
  logic        scanTck, scanTms, scanTdi, scanTdoPin, evtValid, evtReady;
  logic        memReq, memWe, memAck, rt;
  logic [3:0]  memLat;
  logic [18:0] memAddr;
  logic [31:0] busRdata, memWdata, memRdata, rd, tdiSeen, tmsSeen, firstAddr;
  logic [75:0] serialPins = 76'hABC_DEF01234_56789ABC;
  rbc_req_t    busCmd;
  rbc_evt_t    evtIn;
  rbc_dma_t    dmaCmd;
  int          miscompares, comparisons, goCount, tckCount, n;
  logic [23:0] evWords [3] = '{24'h5, 24'hFF, 24'h100};
  logic [11:0] evBx [3] = '{12'h7, 12'h7, 12'hFFF};

  rbc_bridge DUT (.clk, .reset, .busReq, .busCmd, .busAck, .busRetry, .busRdata, .intReq,
    .serialPins, .spyValid, .dmaGo, .dmaCmd, .dmaDone, .scanTck, .scanTms, .scanTdi,
    .scanTdoPin, .evtValid, .evtIn, .evtReady, .memReq, .memWe, .memAddr, .memWdata,
    .memAck, .memRdata);
  rbc_far_model far (.clk, .reset, .memLat, .memReq, .memWe, .memAddr, .memWdata, .memAck,
    .memRdata, .scanTck, .scanTdi, .scanTdoPin, .dmaGo, .dmaDone);

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  always @(posedge scanTck) begin
    tdiSeen[tckCount] <= scanTdi;
    tmsSeen[tckCount] <= scanTms;
    tckCount <= tckCount + 1;
  end
  always @(posedge clk) begin
    if (dmaGo) begin
      if (goCount == 0) firstAddr <= dmaCmd.addr;
      goCount <= goCount + 1;
    end
  end

  task automatic chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one request outstanding; released in the same cycle as its answer
  task automatic acc(input logic c, w, input logic [21:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(negedge clk);
    busCmd = '{cfg: c, wr: w, addr: a, data: d};
    busReq = 1'h1;
    do begin
      @(negedge clk);
      k++;
    end while (!busAck && !busRetry && k < 400);
    if (k >= 400) begin
      miscompares++;
      $display("[FAIL] %0t bus answer timeout", $time);
    end
    rd = busRdata;
    rt = busRetry;
    busReq = 1'h0;
  endtask
  task automatic wr(input logic [21:0] a, input logic [31:0] d);
    acc(1'h0, 1'h1, a, d);
  endtask
  task automatic rdk(input logic c, input logic [21:0] a, input logic [31:0] e);
    acc(c, 1'h0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic evt(input int k);
    @(negedge clk);
    n = 0;
    while (!evtReady && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n >= 400) begin
      miscompares++;
      $display("[FAIL] %0t event ready timeout", $time);
    end
    evtValid = 1'h1;
    evtIn = '{words: evWords[k], bx: evBx[k], src: 12'hA5};
    @(negedge clk);
    evtValid = 1'h0;
  endtask
  task automatic end_of_test;
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #1200000;
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test;
  end

  initial begin
    busReq = 1'h0;
    busCmd = '0;
    spyValid = 1'h0;
    evtValid = 1'h0;
    evtIn = '0;
    memLat = 4'h0;
    reset = 1'h1;
    repeat (4) @(negedge clk);
    reset = 1'h0;
    rdk(1'h0, OFF_CTRL, 32'h3);
    acc(1'h1, 1'h1, OFF_SER_LO, 32'h0);
    rdk(1'h1, OFF_SER_LO, 32'h56789ABC);
    rdk(1'h1, OFF_SER_MID, 32'hDEF01234);
    rdk(1'h1, OFF_SER_HI, 32'hABC);
    rdk(1'h0, 22'h000040, 32'h0);
    wr(OFF_CTRL, 32'h100);
    @(negedge clk);
    chk({31'h0, intReq}, 32'h1);
    rdk(1'h0, OFF_CTRL, 32'h103);
    wr(OFF_BSIZE, 32'hFFFFFFFF);
    wr(OFF_SZBASE, 32'hFFFFFFFF);
    wr(OFF_PTRUPD, 32'hFFFFFFFF);
    rdk(1'h0, OFF_BSIZE, BSIZE_MSK);
    rdk(1'h0, OFF_SZBASE, SZB_MSK);
    rdk(1'h0, OFF_PTRUPD, 32'hFFFFFFFF);
    // one more than the depth: the last is dropped
    for (int i = 0; i <= FIFO_DEPTH; i++) begin
      wr(OFF_BLKADDR, 32'h1000 + i);
      if (i == 32) begin
        rdk(1'h0, OFF_CTRL, 32'h100);
        chk({31'h0, intReq}, 32'h0);
      end
    end
    // half-empty interrupt and spy enabled, empty interrupt off: quiet while full, raised once drained
    wr(OFF_CTRL, 32'h600);
    spyValid = 1'h1;
    @(negedge clk);
    chk({31'h0, intReq}, 32'h0);
    n = 0;
    while (goCount < FIFO_DEPTH + 1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk(goCount, FIFO_DEPTH);
    chk(firstAddr, 32'h1000);
    chk(dmaCmd.size, BSIZE_MSK);
    chk(dmaCmd.szBase, SZB_MSK);
    chk(dmaCmd.ptrAddr, 32'hFFFFFFFF);
    chk({31'h0, intReq}, 32'h1);
    rdk(1'h0, OFF_CTRL, 32'h603);
    wr(OFF_MASK, 32'hFF);
    wr(OFF_TMS, 32'hA5);
    wr(OFF_TDI, 32'h3C);
    acc(1'h0, 1'h0, OFF_TDO, 32'h0);
    chk({31'h0, rt}, 32'h1);
    n = 0;
    while (rt && n < 100) begin
      acc(1'h0, 1'h0, OFF_TDO, 32'h0);
      n++;
    end
    chk(rd, 32'h79);
    chk(tckCount, 8);
    chk({24'h0, tdiSeen[7:0]}, 32'h3C);
    chk({24'h0, tmsSeen[7:0]}, 32'hA5);
    rdk(1'h0, OFF_MASK, 32'hFF);
    memLat = 4'h5;
    wr(22'h200010, 32'hCAFE0001);
    rdk(1'h0, 22'h200010, 32'hCAFE0001);
    memLat = 4'h0;
    for (int k = 0; k < 3; k++) evt(k);
    n = 0;
    do begin
      acc(1'h0, 1'h0, 22'h200408, 32'h0);
      n++;
    end while (rd !== 32'h204 && n < 50);
    chk(rd, 32'h204);
    rdk(1'h0, 22'h200014, 32'h1);
    rdk(1'h0, 22'h2003FC, 32'h1);
    rdk(1'h0, 22'h200400, 32'h1);
    rdk(1'h0, 22'h20401C, 32'h2);
    rdk(1'h0, 22'h207FFC, 32'h1);
    rdk(1'h0, 22'h200404, 32'hA5);
    rdk(1'h0, 22'h20040C, 32'h0);
    wr(OFF_CTRL, 32'h20000);
    repeat (3) @(negedge clk);
    rdk(1'h0, OFF_BSIZE, 32'h0);
    rdk(1'h0, OFF_CTRL, 32'h3);
    end_of_test;
  end
endmodule // tb_readout_bridge_control_map
